// *** rtl/pmc_pkg.sv ***
// package: power mode control constants and types
`default_nettype none
package pmc_pkg;
    // =====================================================
    // bit positions in the control registers
    localparam int unsigned IDLE_BIT = 0;
    localparam int unsigned STOP_BIT = 1;
    localparam int unsigned SUSPEND_BIT = 5;
    // =====================================================
    // reset values
    localparam logic [7:0] PWR_CTRL_RESET = 8'h00;
    localparam logic [7:0] OSC_RESET = 8'h00;
    // =====================================================
    // modes
    typedef enum logic [1:0] {
        PMC_ACTIVE,
        PMC_IDLE,
        PMC_SUSPEND,
        PMC_STOP
    } pmc_mode_e;
endpackage
`default_nettype wire

// *** rtl/pmc_wake_edge.sv ***
// file: comparator edge detector used as a wakening source
`timescale 1ns/1ps
`default_nettype none
module pmc_wake_edge (
    input wire logic mclk,
    input wire logic rst,
    input wire logic ce,
    input wire logic level,
    input wire logic en,
    input wire logic rise_en,
    input wire logic fall_en,
    output logic hit
);
    // =====================================================
    // state
    typedef struct packed {
        logic prev;
    } pmc_edge_s;
    pmc_edge_s st;
    pmc_edge_s next_st;

    always_comb begin
        next_st = st;
        next_st.prev = level;
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            // take the live level so a high comparator gives no false edge after reset
            st.prev <= level;
        end else if (ce) begin
            st <= next_st;
        end
    end

    // rising, falling or either edge
    assign hit = en && ((rise_en && level && !st.prev) || (fall_en && !level && st.prev)); // R10
endmodule // pmc_wake_edge
`default_nettype wire

// *** rtl/pmc_power_mode.sv ***
// file: power mode control top
// =====================================================
// Overview of operation
// R1 - four modes: active, idle, suspend, stop; active after reset
// R2 - idle halts cpu fetch, system clock and peripheral clocks keep running
// R3 - idle entered by control bit 0; left on enabled interrupt or reset
// R4 - suspend gates the system clock until a wakening event
// R5 - in suspend enabled peripherals hold configuration, cpu fetches nothing
// R6 - suspend entered by osc bit 5; left on wake, external or clock-loss reset
// R7 - stop halts cpu, interrupts, timers and internal oscillator
// R8 - in stop digital peripherals off, analog kept per user setting
// R9 - stop entered by control bit 1; left only on external or clock-loss reset
// R10 - enabled comparator edge wakes from idle or suspend
// R11 - clock alarm or its oscillator loss restarts oscillator, ends suspend; int_osc_en stays high in suspend, so only the system clock restarts
// R12 - request bits self-clear on return to active or system clock restart
`timescale 1ns/1ps
`default_nettype none
module pmc_power_mode (
    input wire logic mclk,
    input wire logic rst,
    input wire logic ce,
    input wire logic power_control_wr,
    input wire logic [7:0] power_control_wdata,
    input wire logic internal_osc_control_wr,
    input wire logic [7:0] internal_osc_control_wdata,
    input wire logic irq_pending,
    input wire logic ext_reset,
    input wire logic missing_clock_detector,
    input wire logic comparator_zero_latched_out,
    input wire logic comparator_one_latched_out,
    input wire logic [1:0] cmp_wake_en,
    input wire logic [1:0] cmp_rise_en,
    input wire logic [1:0] cmp_fall_en,
    input wire logic rtc_alarm,
    input wire logic rtc_osc_fail,
    input wire logic analog_en,
    output logic [7:0] power_control_reg,
    output logic [7:0] internal_osc_control_reg,
    output logic [1:0] mode,
    output logic cpu_run,
    output logic system_clock_net_en,
    output logic periph_clk_en,
    output logic irq_timer_en,
    output logic int_osc_en,
    output logic digital_periph_en,
    output logic analog_periph_en
);
    // =====================================================
    // state
    typedef struct packed {
        pmc_pkg::pmc_mode_e mode;
        logic [7:0] pwr;
        logic [7:0] osc;
        logic cpu_run;
        logic sys_en;
        logic per_en;
        logic irq_en;
        logic osc_en;
        logic dig_en;
        logic ana_en;
    } pmc_state_s;
    pmc_state_s st;
    pmc_state_s next_st;

    logic [1:0] cmp_hit;
    logic [1:0] cmp_lvl;
    logic wake;
    logic hard_reset;

    assign cmp_lvl = {comparator_one_latched_out, comparator_zero_latched_out};

    // =====================================================
    // comparator wake sources
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_cmp
            pmc_wake_edge u_edge (
                .mclk(mclk),
                .rst(rst),
                .ce(ce),
                .level(cmp_lvl[gi]),
                .en(cmp_wake_en[gi]),
                .rise_en(cmp_rise_en[gi]),
                .fall_en(cmp_fall_en[gi]),
                .hit(cmp_hit[gi])
            );
        end
    endgenerate

    assign wake = (|cmp_hit) || rtc_alarm || rtc_osc_fail; // R10 R11
    assign hard_reset = ext_reset || missing_clock_detector;

    // =====================================================
    // mode sequencing
    always_comb begin
        next_st = st;
        case (st.mode)
            pmc_pkg::PMC_ACTIVE: begin
                if (power_control_wr) begin
                    next_st.pwr = power_control_wdata;
                    // stop takes priority over idle when both are written
                    if (power_control_wdata[pmc_pkg::STOP_BIT]) begin
                        next_st.mode = pmc_pkg::PMC_STOP; // R9
                    end else if (power_control_wdata[pmc_pkg::IDLE_BIT]) begin
                        next_st.mode = pmc_pkg::PMC_IDLE; // R3
                    end
                end else if (internal_osc_control_wr) begin
                    next_st.osc = internal_osc_control_wdata;
                    if (internal_osc_control_wdata[pmc_pkg::SUSPEND_BIT]) begin
                        next_st.mode = pmc_pkg::PMC_SUSPEND; // R6
                    end
                end
            end
            pmc_pkg::PMC_IDLE: begin
                if (irq_pending || hard_reset || wake) begin
                    next_st.mode = pmc_pkg::PMC_ACTIVE; // R3 R10
                    next_st.pwr[pmc_pkg::IDLE_BIT] = 1'b0; // R12
                end
            end
            pmc_pkg::PMC_SUSPEND: begin
                // interrupts alone do not end suspend
                if (wake || hard_reset) begin
                    next_st.mode = pmc_pkg::PMC_ACTIVE; // R6
                    next_st.osc[pmc_pkg::SUSPEND_BIT] = 1'b0; // R12
                end
            end
            pmc_pkg::PMC_STOP: begin
                if (hard_reset) begin
                    next_st.mode = pmc_pkg::PMC_ACTIVE; // R9
                    // a combined write leaves the idle bit set as well
                    next_st.pwr[pmc_pkg::STOP_BIT] = 1'b0; // R12
                    next_st.pwr[pmc_pkg::IDLE_BIT] = 1'b0; // R12
                end
            end
            default: begin
                next_st.mode = pmc_pkg::PMC_ACTIVE;
            end
        endcase
        // gating follows the next mode so outputs match mode in the same cycle
        next_st.cpu_run = (next_st.mode == pmc_pkg::PMC_ACTIVE); // R2 R5 R7
        next_st.sys_en = (next_st.mode == pmc_pkg::PMC_ACTIVE)
            || (next_st.mode == pmc_pkg::PMC_IDLE); // R2 R4
        next_st.per_en = next_st.sys_en; // R4
        next_st.irq_en = (next_st.mode != pmc_pkg::PMC_STOP); // R7
        next_st.osc_en = (next_st.mode != pmc_pkg::PMC_STOP); // R7
        next_st.dig_en = (next_st.mode != pmc_pkg::PMC_STOP); // R8
        next_st.ana_en = analog_en; // R5 R8
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            st.mode <= pmc_pkg::PMC_ACTIVE; // R1
            st.pwr <= pmc_pkg::PWR_CTRL_RESET;
            st.osc <= pmc_pkg::OSC_RESET;
            st.cpu_run <= 1'b1;
            st.sys_en <= 1'b1;
            st.per_en <= 1'b1;
            st.irq_en <= 1'b1;
            st.osc_en <= 1'b1;
            st.dig_en <= 1'b1;
            st.ana_en <= 1'b0;
        end else if (ce) begin
            st <= next_st;
        end
    end

    assign mode = st.mode;
    assign power_control_reg = st.pwr;
    assign internal_osc_control_reg = st.osc;
    assign cpu_run = st.cpu_run;
    assign system_clock_net_en = st.sys_en;
    assign periph_clk_en = st.per_en;
    assign irq_timer_en = st.irq_en;
    assign int_osc_en = st.osc_en;
    assign digital_periph_en = st.dig_en;
    assign analog_periph_en = st.ana_en;

    // =====================================================
    // checks
    a_stop_only_reset: assert property (@(posedge mclk) disable iff (rst) // R9
        (st.mode == pmc_pkg::PMC_STOP && ce && !hard_reset) |=> st.mode == pmc_pkg::PMC_STOP)
        else $error("stop left without reset");
    a_idle_irq_exit: assert property (@(posedge mclk) disable iff (rst) // R3
        (st.mode == pmc_pkg::PMC_IDLE && ce && irq_pending) |=> cpu_run
        && !power_control_reg[pmc_pkg::IDLE_BIT])
        else $error("idle not left on interrupt");
    a_susp_wake_exit: assert property (@(posedge mclk) disable iff (rst) // R6
        (st.mode == pmc_pkg::PMC_SUSPEND && ce && wake) |=> system_clock_net_en
        && !internal_osc_control_reg[pmc_pkg::SUSPEND_BIT])
        else $error("suspend not left on wake");
    a_susp_clock_off: assert property (@(posedge mclk) disable iff (rst) // R4
        st.mode == pmc_pkg::PMC_SUSPEND |-> !system_clock_net_en && !cpu_run)
        else $error("clock running in suspend");
    a_idle_clock_on: assert property (@(posedge mclk) disable iff (rst) // R2
        st.mode == pmc_pkg::PMC_IDLE |-> system_clock_net_en && !cpu_run)
        else $error("idle gating wrong");
    a_stop_osc_off: assert property (@(posedge mclk) disable iff (rst) // R7
        st.mode == pmc_pkg::PMC_STOP |-> !int_osc_en && !irq_timer_en && !digital_periph_en)
        else $error("stop gating wrong");
    a_stop_entry: assert property (@(posedge mclk) disable iff (rst) // R9
        (st.mode == pmc_pkg::PMC_ACTIVE && ce && power_control_wr
        && power_control_wdata[pmc_pkg::STOP_BIT])
        |=> st.mode == pmc_pkg::PMC_STOP)
        else $error("stop not entered");
    a_susp_irq_hold: assert property (@(posedge mclk) disable iff (rst) // R6
        (st.mode == pmc_pkg::PMC_SUSPEND && ce && !wake && !hard_reset)
        |=> st.mode == pmc_pkg::PMC_SUSPEND)
        else $error("suspend left without wake");
    // entry and return steps shared by the properties below
    sequence s_idle_entry;
        st.mode == pmc_pkg::PMC_ACTIVE && ce && power_control_wr
            && power_control_wdata[pmc_pkg::IDLE_BIT]
            && !power_control_wdata[pmc_pkg::STOP_BIT];
    endsequence
    sequence s_idle_held;
        st.mode == pmc_pkg::PMC_IDLE && !cpu_run && power_control_reg[pmc_pkg::IDLE_BIT];
    endsequence
    sequence s_susp_entry;
        st.mode == pmc_pkg::PMC_ACTIVE && ce && !power_control_wr && internal_osc_control_wr
            && internal_osc_control_wdata[pmc_pkg::SUSPEND_BIT];
    endsequence
    sequence s_susp_held;
        st.mode == pmc_pkg::PMC_SUSPEND && !system_clock_net_en && !periph_clk_en;
    endsequence
    sequence s_back_to_active;
        (st.mode != pmc_pkg::PMC_ACTIVE) ##1 (st.mode == pmc_pkg::PMC_ACTIVE);
    endsequence
    sequence s_requests_clear;
        !power_control_reg[pmc_pkg::IDLE_BIT] && !power_control_reg[pmc_pkg::STOP_BIT]
            && !internal_osc_control_reg[pmc_pkg::SUSPEND_BIT];
    endsequence
    a_idle_entry: assert property (@(posedge mclk) disable iff (rst) // R3
        s_idle_entry |=> s_idle_held)
        else $error("idle not entered");
    a_susp_entry: assert property (@(posedge mclk) disable iff (rst) // R6
        s_susp_entry |=> s_susp_held)
        else $error("suspend not entered");
    a_request_clear: assert property (@(posedge mclk) disable iff (rst) // R12
        s_back_to_active |-> s_requests_clear)
        else $error("request bit left set in active");
    a_analog_follow: assert property (@(posedge mclk) disable iff (rst) // R8
        ce |=> analog_periph_en == $past(analog_en))
        else $error("analog enable not followed");
endmodule // pmc_power_mode
`default_nettype wire

// *** testbench/test_power_mode_control.sv ***
// testbench: directed scenarios for the power mode control block
`timescale 1ns/1ps
`default_nettype none
module test_power_mode_control;
    logic mclk = 1'b0, rst = 1'b1, ce = 1'b1, irq_pending = 1'b0, ext_reset = 1'b0;
    logic power_control_wr = 1'b0, internal_osc_control_wr = 1'b0, analog_en = 1'b0;
    logic [7:0] power_control_wdata = 8'h00, internal_osc_control_wdata = 8'h00;
    logic missing_clock_detector = 1'b0, rtc_alarm = 1'b0, rtc_osc_fail = 1'b0;
    logic comparator_zero_latched_out = 1'b0, comparator_one_latched_out = 1'b0;
    logic [1:0] cmp_wake_en = 2'h0, cmp_rise_en = 2'h0, cmp_fall_en = 2'h0, mode;
    logic [7:0] power_control_reg, internal_osc_control_reg;
    logic cpu_run, system_clock_net_en, periph_clk_en, irq_timer_en, int_osc_en;
    logic digital_periph_en, analog_periph_en;
    logic [5:0] gates;
    int bad_count = 0, n_checks = 0;
    assign gates = {cpu_run, system_clock_net_en, periph_clk_en, irq_timer_en, int_osc_en,
        digital_periph_en};
    pmc_power_mode dut_u (.mclk, .rst, .ce, .power_control_wr, .power_control_wdata,
        .internal_osc_control_wr, .internal_osc_control_wdata, .irq_pending, .ext_reset,
        .missing_clock_detector, .comparator_zero_latched_out, .comparator_one_latched_out,
        .cmp_wake_en, .cmp_rise_en, .cmp_fall_en, .rtc_alarm, .rtc_osc_fail, .analog_en,
        .power_control_reg, .internal_osc_control_reg, .mode, .cpu_run,
        .system_clock_net_en, .periph_clk_en, .irq_timer_en, .int_osc_en,
        .digital_periph_en, .analog_periph_en);
    // =====================================================
    // shared tasks
    initial begin
        forever #2.5 mclk = ~mclk;
    end
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic finish_test;
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic step(input int n);
        repeat (n) @(negedge mclk);
    endtask
    // strobes rise at a falling edge, so the rising edge between takes them
    task automatic wr(input logic pw, input logic [7:0] pd, input logic ow, input logic [7:0] od);
        power_control_wr = pw;
        power_control_wdata = pd;
        internal_osc_control_wr = ow;
        internal_osc_control_wdata = od;
        step(1);
        power_control_wr = 1'b0;
        internal_osc_control_wr = 1'b0;
        // spare cycle so a following call never rewrites a strobe in one step
        step(1);
    endtask
    task automatic expect_mode(input logic [1:0] m, input logic [5:0] g);
        check({6'h00, mode}, {6'h00, m});
        check({2'h0, gates}, {2'h0, g});
    endtask
    // =====================================================
    // scenarios
    task automatic t_idle;
        wr(1'b1, 8'h01, 1'b0, 8'h00);
        expect_mode(2'h1, 6'h1f);
        check(power_control_reg, 8'h01);
        wr(1'b0, 8'h00, 1'b1, 8'h20);
        expect_mode(2'h1, 6'h1f);
        irq_pending = 1'b1;
        step(1);
        irq_pending = 1'b0;
        expect_mode(2'h0, 6'h3f);
        check(power_control_reg & 8'h01, 8'h00);
        $display("idle test done");
    endtask
    task automatic t_stop;
        cmp_wake_en = 2'h1;
        cmp_rise_en = 2'h1;
        wr(1'b1, 8'h03, 1'b0, 8'h00);
        expect_mode(2'h3, 6'h00);
        irq_pending = 1'b1;
        rtc_alarm = 1'b1;
        comparator_zero_latched_out = 1'b1;
        step(3);
        expect_mode(2'h3, 6'h00);
        irq_pending = 1'b0;
        rtc_alarm = 1'b0;
        ext_reset = 1'b1;
        step(1);
        ext_reset = 1'b0;
        expect_mode(2'h0, 6'h3f);
        check(power_control_reg, 8'h00);
        $display("stop test done");
    endtask
    task automatic t_suspend;
        for (int i = 0; i < 3; i++) begin
            wr(1'b0, 8'h00, 1'b1, 8'h20);
            expect_mode(2'h2, 6'h07);
            check(internal_osc_control_reg, 8'h20);
            irq_pending = 1'b1;
            step(1);
            irq_pending = 1'b0;
            expect_mode(2'h2, 6'h07);
            {missing_clock_detector, rtc_osc_fail, rtc_alarm} = 3'h1 << i;
            step(1);
            {missing_clock_detector, rtc_osc_fail, rtc_alarm} = 3'h0;
            expect_mode(2'h0, 6'h3f);
            check(internal_osc_control_reg & 8'h20, 8'h00);
        end
        $display("suspend test done");
    endtask
    // an edge counts at the first rising clock edge after the level moves
    task automatic t_cmp;
        cmp_wake_en = 2'h3;
        cmp_fall_en = 2'h2;
        wr(1'b0, 8'h00, 1'b1, 8'h20);
        comparator_zero_latched_out = 1'b0;
        step(2);
        expect_mode(2'h2, 6'h07);
        comparator_zero_latched_out = 1'b1;
        step(2);
        expect_mode(2'h0, 6'h3f);
        comparator_one_latched_out = 1'b1;
        step(2);
        wr(1'b1, 8'h01, 1'b0, 8'h00);
        comparator_one_latched_out = 1'b0;
        step(2);
        expect_mode(2'h0, 6'h3f);
        $display("comparator test done");
    endtask
    task automatic t_misc;
        wr(1'b1, 8'h01, 1'b1, 8'h20);
        expect_mode(2'h1, 6'h1f);
        check(internal_osc_control_reg, 8'h00);
        irq_pending = 1'b1;
        step(1);
        irq_pending = 1'b0;
        ce = 1'b0;
        wr(1'b1, 8'h02, 1'b0, 8'h00);
        ce = 1'b1;
        expect_mode(2'h0, 6'h3f);
        analog_en = 1'b1;
        step(1);
        check({7'h00, analog_periph_en}, 8'h01);
        wr(1'b1, 8'h02, 1'b0, 8'h00);
        expect_mode(2'h3, 6'h00);
        rst = 1'b1;
        step(1);
        rst = 1'b0;
        expect_mode(2'h0, 6'h3f);
        check(power_control_reg | internal_osc_control_reg, 8'h00);
        check({7'h00, analog_periph_en}, 8'h00);
        step(1);
        check({7'h00, analog_periph_en}, 8'h01);
        $display("misc test done");
    endtask
    // =====================================================
    // main sequence and hang guard
    initial begin
        step(3);
        rst = 1'b0;
        expect_mode(2'h0, 6'h3f);
        check(power_control_reg | internal_osc_control_reg, 8'h00);
        check({7'h00, analog_periph_en}, 8'h00);
        t_idle();
        t_stop();
        t_suspend();
        t_cmp();
        t_misc();
        finish_test();
    end
    initial begin
        #100000;
        bad_count++;
        $display("CHECK FAILED at %0t: run did not end", $time);
        finish_test();
    end
endmodule // test_power_mode_control
`default_nettype wire
